// ===== src/mac_unit.sv
// Multiply-accumulate datapath with its operand, configuration and window registers
`timescale 1ns/1ps
`default_nettype none
`include "mac_cfg.svh"

module mac_unit
  import mac_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  // Register port from the core
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic [7:0]  i_sfr_wdata,
  input  wire logic        i_sfr_rd,
  output logic      [7:0]  o_sfr_rdata,
  output logic             o_sfr_hit,
  // Operation requests from the core
  input  wire logic        i_op_valid,
  input  wire logic        i_op_prefixed,
  input  wire logic [7:0]  i_op_code,
  output logic             o_op_busy,
  output logic             o_op_done,
  // Status word flags
  input  wire logic        i_wrap_clr,
  output logic             o_carry,
  output logic             o_carry_valid,
  output logic             o_twos_wrap_flag,
  // Configuration byte for neighbouring logic
  output logic      [7:0]  o_signal_proc_config
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] place_partial(input logic [17:0] p, input logic [4:0] sh);
    logic [31:0] w;
    w = {{14{p[17]}}, p};
    return w << sh;
  endfunction

  function automatic logic [39:0] set_byte(input logic [39:0] s, input logic [2:0] idx, input logic [7:0] v);
    logic [39:0] r;
    r = s;
    r[{idx, 3'b000} +: 8] = v;
    return r;
  endfunction

  function automatic logic [3:0] op_length(input mac_state_t st);
    logic [3:0] n;
    n = 4'h1;
    case (st)
      MAC_ST_MAC:   n = `MAC_CYC_MULTIPLY_ADD;
      MAC_ST_BYTE:  n = `MAC_CYC_BYTE_PRODUCT;
      MAC_ST_CLEAR: n = `MAC_CYC_CLEAR_SUM;
      MAC_ST_SHIFT: n = `MAC_CYC_SHIFT;
      default:      n = 4'h1;
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  primary_low_ff;
  logic [7:0]  first_high_ff;
  logic [7:0]  secondary_low_ff;
  logic [7:0]  second_high_ff;
  logic [7:0]  config_ff;
  logic [39:0] sum_ff;
  logic [31:0] prod_ff;
  logic [3:0]  cnt_ff;
  mac_state_t  state_ff;
  mac_state_t  nxt_state;
  mac_dir_t    dir_ff;
  logic        carry_ff;
  logic        carry_valid_ff;
  logic        wrap_ff;
  logic [7:0]  rdata_ff;
  logic        hit_ff;

  logic [1:0]  window_sel;
  logic        signed_first_sel;
  logic        signed_second_sel;
  logic [2:0]  win_low_index;
  logic [7:0]  win_low_byte;
  logic [7:0]  win_high_byte;
  logic        last_cycle;
  logic        take_op;
  logic [7:0]  mul_a;
  logic [7:0]  mul_b;
  logic        mul_a_signed;
  logic        mul_b_signed;
  logic [17:0] mul_p;
  logic [4:0]  pp_shift;
  logic [31:0] pp_placed;
  logic [40:0] sum_ext;
  logic        wr_win_low;
  logic        wr_win_high;

  assign window_sel        = config_ff[`MAC_WSEL_MSB:`MAC_WSEL_LSB];
  assign signed_first_sel  = config_ff[`MAC_SIGNED_FIRST_BIT];
  assign signed_second_sel = config_ff[`MAC_SIGNED_SECOND_BIT];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign last_cycle = (state_ff != MAC_ST_IDLE) && (cnt_ff == op_length(state_ff) - 4'h1);
  assign take_op    = i_op_valid && (state_ff == MAC_ST_IDLE);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MAC_ST_IDLE: begin
        if (take_op) begin
          if (i_op_prefixed) begin
            case (i_op_code)
              `MAC_OPC_MULTIPLY_ADD: nxt_state = MAC_ST_MAC;
              `MAC_OPC_CLEAR_SUM:    nxt_state = MAC_ST_CLEAR;
              `MAC_OPC_LEFT_SHIFT:   nxt_state = MAC_ST_SHIFT;
              `MAC_OPC_RIGHT_SHIFT:  nxt_state = MAC_ST_SHIFT;
              default:               nxt_state = MAC_ST_IDLE;
            endcase
          end else if (i_op_code == `MAC_OPC_BYTE_PRODUCT) begin
            nxt_state = MAC_ST_BYTE;
          end
        end
      end
      MAC_ST_MAC, MAC_ST_BYTE, MAC_ST_CLEAR, MAC_ST_SHIFT: begin
        if (last_cycle) begin
          nxt_state = MAC_ST_IDLE;
        end
      end
      default: nxt_state = MAC_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= MAC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff <= 4'h0;
    end else if (state_ff == MAC_ST_IDLE || last_cycle) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dir_ff <= MAC_DIR_LEFT;
    end else if (take_op) begin
      dir_ff <= (i_op_code == `MAC_OPC_RIGHT_SHIFT) ? MAC_DIR_RIGHT : MAC_DIR_LEFT;
    end
  end

  assign o_op_busy = (state_ff != MAC_ST_IDLE);
  assign o_op_done = last_cycle;

  // ----------------------------------------------------------------
  // Shared byte multiplier and partial products
  // ----------------------------------------------------------------
  // One byte multiplier is reused for both operations, which is why the 16x16 product takes four steps
  always_comb begin
    mul_a        = primary_low_ff;
    mul_b        = secondary_low_ff;
    mul_a_signed = 1'b0;
    mul_b_signed = 1'b0;
    pp_shift     = 5'd0;
    if (state_ff == MAC_ST_MAC) begin
      case (cnt_ff[1:0])
        2'b00: begin
          pp_shift = 5'd0;
        end
        2'b01: begin
          mul_a        = first_high_ff;
          mul_a_signed = 1'b1;
          pp_shift     = 5'd8;
        end
        2'b10: begin
          mul_b        = second_high_ff;
          mul_b_signed = 1'b1;
          pp_shift     = 5'd8;
        end
        default: begin
          mul_a        = first_high_ff;
          mul_b        = second_high_ff;
          mul_a_signed = 1'b1;
          mul_b_signed = 1'b1;
          pp_shift     = 5'd16;
        end
      endcase
    end else begin
      mul_a_signed = signed_first_sel;
      mul_b_signed = signed_second_sel;
    end
  end

  mac_byte_mult u_byte_mult (
    .i_a        (mul_a),
    .i_a_signed (mul_a_signed),
    .i_b        (mul_b),
    .i_b_signed (mul_b_signed),
    .o_product  (mul_p)
  );

  assign pp_placed = place_partial(mul_p, pp_shift);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prod_ff <= 32'h0000_0000;
    end else if (state_ff == MAC_ST_MAC && cnt_ff < `MAC_CYC_ADD_STEP) begin
      prod_ff <= (cnt_ff == 4'h0) ? pp_placed : prod_ff + pp_placed;
    end
  end

  // ----------------------------------------------------------------
  // Forty-bit sum
  // ----------------------------------------------------------------
  assign sum_ext = {sum_ff[39], sum_ff} + {{9{prod_ff[31]}}, prod_ff};

  mac_window u_window (
    .i_sum       (sum_ff),
    .i_sel       (window_sel),
    .o_low_index (win_low_index),
    .o_low_byte  (win_low_byte),
    .o_high_byte (win_high_byte)
  );

  assign wr_win_low  = i_sfr_wr && (i_sfr_addr == `MAC_OFS_WINDOW_LOW);
  assign wr_win_high = i_sfr_wr && (i_sfr_addr == `MAC_OFS_WINDOW_HIGH);

  // A running operation owns the sum; a window write in the same cycle is dropped
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sum_ff <= `MAC_RST_SUM;
    end else if (state_ff == MAC_ST_MAC && cnt_ff == `MAC_CYC_ADD_STEP) begin
      sum_ff <= sum_ext[39:0];
    end else if (state_ff == MAC_ST_CLEAR && cnt_ff == 4'h0) begin
      sum_ff <= `MAC_RST_SUM;
    end else if (state_ff == MAC_ST_SHIFT && cnt_ff == 4'h0) begin
      if (dir_ff == MAC_DIR_RIGHT) begin
        sum_ff <= {sum_ff[39], sum_ff[39:1]};
      end else begin
        sum_ff <= {sum_ff[38:0], 1'b0};
      end
    end else if (state_ff == MAC_ST_IDLE && wr_win_low) begin
      sum_ff <= set_byte(sum_ff, win_low_index, i_sfr_wdata);
    end else if (state_ff == MAC_ST_IDLE && wr_win_high) begin
      sum_ff <= set_byte(sum_ff, win_low_index + 3'd1, i_sfr_wdata);
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      carry_ff       <= 1'b0;
      carry_valid_ff <= 1'b0;
    end else if (state_ff == MAC_ST_MAC && cnt_ff == `MAC_CYC_ADD_STEP) begin
      carry_ff       <= sum_ext[39];
      carry_valid_ff <= 1'b1;
    end else begin
      carry_valid_ff <= 1'b0;
    end
  end

  // Overflow shows as a mismatch between the guard bit and the sign bit
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wrap_ff <= 1'b0;
    end else if (state_ff == MAC_ST_MAC && cnt_ff == `MAC_CYC_ADD_STEP && (sum_ext[40] ^ sum_ext[39])) begin
      wrap_ff <= 1'b1;
    end else if (i_wrap_clr) begin
      wrap_ff <= 1'b0;
    end
  end

  assign o_carry          = carry_ff;
  assign o_carry_valid    = carry_valid_ff;
  assign o_twos_wrap_flag = wrap_ff;

  // ----------------------------------------------------------------
  // Operand registers
  // ----------------------------------------------------------------
  // The byte product writes its result back, high byte to the secondary register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      primary_low_ff   <= `MAC_RST_BYTE;
      secondary_low_ff <= `MAC_RST_BYTE;
    end else if (state_ff == MAC_ST_BYTE && cnt_ff == 4'h0) begin
      primary_low_ff   <= mul_p[7:0];
      secondary_low_ff <= mul_p[15:8];
    end else if (state_ff == MAC_ST_IDLE && i_sfr_wr) begin
      if (i_sfr_addr == `MAC_OFS_PRIMARY_LOW) begin
        primary_low_ff <= i_sfr_wdata;
      end
      if (i_sfr_addr == `MAC_OFS_SECONDARY_LOW) begin
        secondary_low_ff <= i_sfr_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      first_high_ff  <= `MAC_RST_BYTE;
      second_high_ff <= `MAC_RST_BYTE;
    end else if (state_ff == MAC_ST_IDLE && i_sfr_wr) begin
      if (i_sfr_addr == `MAC_OFS_FIRST_HIGH) begin
        first_high_ff <= i_sfr_wdata;
      end
      if (i_sfr_addr == `MAC_OFS_SECOND_HIGH) begin
        second_high_ff <= i_sfr_wdata;
      end
    end
  end

  // Configuration may change mid-operation; the multiply-add ignores the sign selects anyway
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      config_ff <= `MAC_RST_BYTE;
    end else if (i_sfr_wr && i_sfr_addr == `MAC_OFS_SP_CONFIG) begin
      config_ff <= i_sfr_wdata & `MAC_CFG_WRITE_MASK;
    end
  end

  assign o_signal_proc_config = config_ff;

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_ff <= `MAC_RST_BYTE;
      hit_ff   <= 1'b0;
    end else if (i_sfr_rd) begin
      hit_ff <= 1'b1;
      case (i_sfr_addr)
        `MAC_OFS_PRIMARY_LOW:   rdata_ff <= primary_low_ff;
        `MAC_OFS_FIRST_HIGH:    rdata_ff <= first_high_ff;
        `MAC_OFS_SP_CONFIG:     rdata_ff <= config_ff;
        `MAC_OFS_WINDOW_LOW:    rdata_ff <= win_low_byte;
        `MAC_OFS_WINDOW_HIGH:   rdata_ff <= win_high_byte;
        `MAC_OFS_SECONDARY_LOW: rdata_ff <= secondary_low_ff;
        `MAC_OFS_SECOND_HIGH:   rdata_ff <= second_high_ff;
        default: begin
          rdata_ff <= `MAC_RST_BYTE;
          hit_ff   <= 1'b0;
        end
      endcase
    end else begin
      rdata_ff <= `MAC_RST_BYTE;
      hit_ff   <= 1'b0;
    end
  end

  assign o_sfr_rdata = rdata_ff;
  assign o_sfr_hit   = hit_ff;

endmodule // mac_unit

`default_nettype wire

// ===== src/mac_cfg.svh
// Offsets, field positions, reset values, opcodes and cycle counts of the multiply-accumulate unit
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MAC_OFS_PRIMARY_LOW     8'hE0
`define MAC_OFS_FIRST_HIGH      8'hE1
`define MAC_OFS_SP_CONFIG       8'hE2
`define MAC_OFS_WINDOW_LOW      8'hE4
`define MAC_OFS_WINDOW_HIGH     8'hE5
`define MAC_OFS_SECONDARY_LOW   8'hF0
`define MAC_OFS_SECOND_HIGH     8'hF7

// ----------------------------------------------------------------
// Reset values and the configuration write mask
// ----------------------------------------------------------------
`define MAC_RST_BYTE            8'h00
`define MAC_RST_SUM             40'h00_0000_0000
`define MAC_CFG_WRITE_MASK      8'h7F

// ----------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------
`define MAC_WSEL_MSB            6
`define MAC_WSEL_LSB            5
`define MAC_SIGNED_SECOND_BIT   4
`define MAC_SIGNED_FIRST_BIT    3

// ----------------------------------------------------------------
// Opcodes: extended ones follow the prefix byte, the byte product does not
// ----------------------------------------------------------------
`define MAC_OPC_MULTIPLY_ADD    8'hA4
`define MAC_OPC_CLEAR_SUM       8'hE4
`define MAC_OPC_LEFT_SHIFT      8'h23
`define MAC_OPC_RIGHT_SHIFT     8'h03
`define MAC_OPC_BYTE_PRODUCT    8'hA4

// ----------------------------------------------------------------
// Cycle counts of each operation and the multiply-add step that updates the sum
// ----------------------------------------------------------------
`define MAC_CYC_MULTIPLY_ADD    4'h9
`define MAC_CYC_CLEAR_SUM       4'h2
`define MAC_CYC_SHIFT           4'h2
`define MAC_CYC_BYTE_PRODUCT    4'h2
`define MAC_CYC_ADD_STEP        4'h4

`endif

// ===== src/mac_pkg.sv
// Types shared by the multiply-accumulate unit
package mac_pkg;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded along idle-mac-byte-clear-shift
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MAC_ST_IDLE  = 3'b000,
    MAC_ST_MAC   = 3'b001,
    MAC_ST_BYTE  = 3'b011,
    MAC_ST_CLEAR = 3'b010,
    MAC_ST_SHIFT = 3'b110
  } mac_state_t;

  typedef enum logic {
    MAC_DIR_LEFT  = 1'b0,
    MAC_DIR_RIGHT = 1'b1
  } mac_dir_t;

endpackage

// ===== src/mac_byte_mult.sv
// Eight-by-eight multiplier with independent signed or unsigned operands
`timescale 1ns/1ps
`default_nettype none

module mac_byte_mult
  import mac_pkg::*;
(
  input  wire logic [7:0]  i_a,
  input  wire logic        i_a_signed,
  input  wire logic [7:0]  i_b,
  input  wire logic        i_b_signed,
  output logic      [17:0] o_product
);

  logic signed [8:0]  a_ext;
  logic signed [8:0]  b_ext;
  logic signed [17:0] prod;

  // A ninth bit turns each operand signed or unsigned on its own
  assign a_ext     = $signed({i_a_signed & i_a[7], i_a});
  assign b_ext     = $signed({i_b_signed & i_b[7], i_b});
  assign prod      = a_ext * b_ext;
  assign o_product = prod;

endmodule // mac_byte_mult

`default_nettype wire

// ===== src/mac_window.sv
// Sliding sixteen-bit view onto the forty-bit sum
`timescale 1ns/1ps
`default_nettype none

module mac_window
  import mac_pkg::*;
(
  input  wire logic [39:0] i_sum,
  input  wire logic [1:0]  i_sel,
  output logic      [2:0]  o_low_index,
  output logic      [7:0]  o_low_byte,
  output logic      [7:0]  o_high_byte
);

  // Select n shows bytes n+1:n, so 10 lands on the upper 1.15 half after one left shift
  assign o_low_index = {1'b0, i_sel};
  assign o_low_byte  = i_sum[{i_sel, 3'b000} +: 8];
  assign o_high_byte = i_sum[{i_sel, 3'b000} + 6'd8 +: 8];

endmodule // mac_window

`default_nettype wire

// ===== verification/mac_core_model.sv
// Behavioural core that issues register accesses and operations
`timescale 1ns/1ps
`default_nettype none

module mac_core_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_hit,
  input  wire logic       i_done,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic      [7:0] o_wdata,
  output logic            o_rd,
  output logic            o_valid,
  output logic            o_prefixed,
  output logic      [7:0] o_code,
  output logic            o_wrap_clr
);
  // ------------------------------------------------------------
  // Requests start 1 ns after an edge and hold to the taking edge
  // ------------------------------------------------------------
  initial begin
    {o_addr, o_wdata, o_code} = 24'h0;
    {o_wr, o_rd, o_valid, o_prefixed, o_wrap_clr} = 5'h0;
  end
  task automatic step();
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step();
    {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
    step();
    o_wr = 1'b0;
    o_wdata = ~d; // Idle data flips so a stale byte never passes for a write
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    step();
    {o_addr, o_rd} = {a, 1'b1};
    step();
    o_rd = 1'b0;
    d = i_rdata;
    h = i_hit;
  endtask
  // Returns the cycle of the done pulse, counted from the taking edge
  task automatic op(input logic p, input logic [7:0] c, output int n);
    step();
    {o_prefixed, o_code, o_valid} = {p, c, 1'b1};
    step();
    o_valid = 1'b0;
    n = 1;
    while (i_done !== 1'b1 && n < 20) begin
      step();
      n++;
    end
  endtask
  task automatic clr_wrap();
    step();
    o_wrap_clr = 1'b1;
    step();
    o_wrap_clr = 1'b0;
  endtask
endmodule // mac_core_model
`default_nettype wire

// ===== verification/mac_unit_chk.sv
// Port-level assertions for the multiply-accumulate unit
`timescale 1ns/1ps
`default_nettype none
`include "mac_cfg.svh"

module mac_unit_chk (
  input wire logic       i_sys_clk,
  input wire logic       i_rstn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_sfr_hit,
  input wire logic       i_op_valid,
  input wire logic       i_op_prefixed,
  input wire logic [7:0] i_op_code,
  input wire logic       o_op_busy,
  input wire logic       o_op_done,
  input wire logic       i_wrap_clr,
  input wire logic       o_carry_valid,
  input wire logic       o_twos_wrap_flag,
  input wire logic [7:0] o_signal_proc_config
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  logic take;
  logic take_mac;
  logic mapped;
  assign take     = i_op_valid && !o_op_busy && i_op_prefixed;
  assign take_mac = take && i_op_code == `MAC_OPC_MULTIPLY_ADD;
  assign mapped   = i_sfr_addr inside {`MAC_OFS_PRIMARY_LOW, `MAC_OFS_FIRST_HIGH, `MAC_OFS_SP_CONFIG,
    `MAC_OFS_WINDOW_LOW, `MAC_OFS_WINDOW_HIGH, `MAC_OFS_SECONDARY_LOW, `MAC_OFS_SECOND_HIGH};
  // ------------------------------------------------------------
  // Operation timing, flags and register port
  // ------------------------------------------------------------
  sequence s_run8; (o_op_busy && !o_op_done) [*8]; endsequence
  sequence s_end; o_op_busy && o_op_done ##1 !o_op_busy; endsequence
  property p_mac_nine; take_mac |=> s_run8 ##1 s_end; endproperty
  a_mac_nine: assert property (p_mac_nine) else $error("multiply-add span wrong");
  property p_clr_two; take && i_op_code == `MAC_OPC_CLEAR_SUM |=> o_op_busy && !o_op_done ##1 s_end; endproperty
  a_clr_two: assert property (p_clr_two) else $error("clear span wrong");
  property p_carry_time; take_mac |-> ##6 o_carry_valid; endproperty
  a_carry_time: assert property (p_carry_time) else $error("carry update late");
  property p_carry_cause; o_carry_valid |-> $past(take_mac, 6); endproperty
  a_carry_cause: assert property (p_carry_cause) else $error("carry update without multiply-add");
  property p_wrap_keep; o_twos_wrap_flag && !i_wrap_clr |=> o_twos_wrap_flag; endproperty
  a_wrap_keep: assert property (p_wrap_keep) else $error("wrap flag dropped");
  property p_wrap_rise; $rose(o_twos_wrap_flag) |-> o_carry_valid; endproperty
  a_wrap_rise: assert property (p_wrap_rise) else $error("wrap flag set outside multiply-add");
  property p_wrap_drop; i_wrap_clr |=> !o_twos_wrap_flag || o_carry_valid; endproperty
  a_wrap_drop: assert property (p_wrap_drop) else $error("wrap flag not cleared");
  property p_rd_hit; i_sfr_rd && mapped |=> o_sfr_hit; endproperty
  a_rd_hit: assert property (p_rd_hit) else $error("mapped read gave no hit");
  property p_rd_miss; i_sfr_rd && !mapped |=> !o_sfr_hit && o_sfr_rdata == 8'h00; endproperty
  a_rd_miss: assert property (p_rd_miss) else $error("unmapped read answered");
  property p_cfg; i_sfr_wr && i_sfr_addr == `MAC_OFS_SP_CONFIG
    |=> o_signal_proc_config == ($past(i_sfr_wdata) & `MAC_CFG_WRITE_MASK); endproperty
  a_cfg: assert property (p_cfg) else $error("config byte not stored");
endmodule // mac_unit_chk
`default_nettype wire

// ===== verification/mac_unit_tb.sv
// Self-checking testbench for the multiply-accumulate unit
`timescale 1ns/1ps
`default_nettype none
`include "mac_cfg.svh"

module mac_unit_tb;
  logic [7:0]  addr, wdata, rdata, code, cfg;
  logic        clk, rst_n, wr, rd, hit, valid, pfx, busy, done, wclr, carry, carry_ok, wrap_flag, wrap;
  logic [39:0] m;
  logic [1:0]  sgn;
  int          err_count, tests_run, cyc;
  mac_unit i_dut (
    .i_sys_clk(clk), .i_rstn(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
    .i_sfr_rd(rd), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_op_valid(valid), .i_op_prefixed(pfx),
    .i_op_code(code), .o_op_busy(busy), .o_op_done(done), .i_wrap_clr(wclr), .o_carry(carry),
    .o_carry_valid(carry_ok), .o_twos_wrap_flag(wrap_flag), .o_signal_proc_config(cfg));
  mac_core_model i_core (
    .i_sys_clk(clk), .i_rdata(rdata), .i_hit(hit), .i_done(done), .o_addr(addr), .o_wr(wr), .o_wdata(wdata),
    .o_rd(rd), .o_valid(valid), .o_prefixed(pfx), .o_code(code), .o_wrap_clr(wclr));
  // ------------------------------------------------------------
  // Clock, comparison, verdict and hang guard
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string w, input logic [39:0] e, input logic [39:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Traffic needs about five hundred and fifty cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 32'h1388) begin
      err_count++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------
  // Sum access through the window, all five bytes
  // ------------------------------------------------------------
  task automatic fill(input logic [39:0] v);
    for (int k = 0; k < 4; k++) begin
      i_core.wr(`MAC_OFS_SP_CONFIG, {1'b0, 2'(k), sgn, 3'h0});
      i_core.wr(`MAC_OFS_WINDOW_LOW, v[8*k +: 8]);
    end
    i_core.wr(`MAC_OFS_WINDOW_HIGH, v[39:32]);
    m = v;
  endtask
  task automatic sum_check(input logic [39:0] e);
    logic [7:0] d;
    logic       h;
    for (int k = 0; k < 4; k++) begin
      i_core.wr(`MAC_OFS_SP_CONFIG, {1'b0, 2'(k), sgn, 3'h0});
      i_core.rd(`MAC_OFS_WINDOW_LOW, d, h);
      chk("window_low", 40'(e[8*k +: 8]), 40'(d));
      i_core.rd(`MAC_OFS_WINDOW_HIGH, d, h);
      chk("window_high", 40'(e[8*k+8 +: 8]), 40'(d));
    end
  endtask
  task automatic do_mac(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    logic [39:0]        r;
    logic [7:0]         d;
    logic               h;
    int                 n;
    i_core.wr(`MAC_OFS_PRIMARY_LOW, a[7:0]);
    i_core.wr(`MAC_OFS_FIRST_HIGH, a[15:8]);
    i_core.wr(`MAC_OFS_SECONDARY_LOW, b[7:0]);
    i_core.wr(`MAC_OFS_SECOND_HIGH, b[15:8]);
    p = $signed(a) * $signed(b);
    r = m + {{8{p[31]}}, p};
    if (m[39] == p[31] && r[39] != m[39]) wrap = 1'b1;
    m = r;
    i_core.op(1'b1, `MAC_OPC_MULTIPLY_ADD, n);
    chk("mac_cycles", 40'h9, 40'(n));
    chk("carry", 40'(m[39]), 40'(carry));
    chk("wrap_flag", 40'(wrap), 40'(wrap_flag));
    i_core.rd(`MAC_OFS_FIRST_HIGH, d, h);
    chk("first_high", 40'(a[15:8]), 40'(d));
    i_core.rd(`MAC_OFS_PRIMARY_LOW, d, h);
    chk("primary_low", 40'(a[7:0]), 40'(d));
    i_core.rd(`MAC_OFS_SECOND_HIGH, d, h);
    chk("second_high", 40'(b[15:8]), 40'(d));
    sum_check(m);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    logic       h;
    logic [7:0] ofs [8] = '{`MAC_OFS_PRIMARY_LOW, `MAC_OFS_FIRST_HIGH, `MAC_OFS_SP_CONFIG,
      `MAC_OFS_WINDOW_LOW, `MAC_OFS_WINDOW_HIGH, `MAC_OFS_SECONDARY_LOW, `MAC_OFS_SECOND_HIGH, 8'hE3};
    for (int k = 0; k < 8; k++) begin
      i_core.rd(ofs[k], d, h);
      chk("reset_value", 40'h0, 40'(d));
      chk("read_hit", 40'(k < 7), 40'(h));
    end
  endtask
  task automatic t_window_clear();
    int n;
    fill(40'h5A_C396_3CE1);
    sum_check(m);
    i_core.op(1'b1, `MAC_OPC_CLEAR_SUM, n);
    m = '0;
    chk("clear_cycles", 40'h2, 40'(n));
    sum_check(m);
  endtask
  task automatic t_shift();
    logic [7:0] d;
    logic       h;
    int         n;
    i_core.op(1'b1, `MAC_OPC_CLEAR_SUM, n);
    m = '0; // A clean sum makes the 1.15 reading exact
    do_mac(16'h4000, 16'h4000);
    i_core.op(1'b1, `MAC_OPC_LEFT_SHIFT, n);
    m = m << 1;
    chk("shift_cycles", 40'h2, 40'(n));
    sum_check(m);
    i_core.wr(`MAC_OFS_SP_CONFIG, {1'b0, 2'h2, sgn, 3'h0});
    i_core.rd(`MAC_OFS_WINDOW_HIGH, d, h);
    chk("fraction_high", 40'h20, 40'(d));
    do_mac(16'h8000, 16'h7FFF);
    i_core.op(1'b1, `MAC_OPC_RIGHT_SHIFT, n);
    m = {m[39], m[39:1]};
    chk("shift_cycles", 40'h2, 40'(n));
    sum_check(m);
  endtask
  task automatic t_wrap();
    fill(40'h7F_FFFF_FFFF);
    do_mac(16'h7FFF, 16'h7FFF);
    do_mac(16'h0001, 16'h0001);
    i_core.clr_wrap();
    wrap = 1'b0;
    chk("wrap_cleared", 40'h0, 40'(wrap_flag));
  endtask
  task automatic t_byte();
    logic signed [17:0] pa, pb, pp;
    logic [7:0]         d;
    logic               h;
    int                 n;
    for (int s = 0; s < 4; s++) begin
      i_core.wr(`MAC_OFS_SP_CONFIG, {3'h4, 2'(s), 3'h5}); // Bit 7 is offered but never stored
      i_core.rd(`MAC_OFS_SP_CONFIG, d, h);
      chk("config", 40'({3'h0, 2'(s), 3'h5}), 40'(d));
      i_core.wr(`MAC_OFS_PRIMARY_LOW, 8'hFE);
      i_core.wr(`MAC_OFS_SECONDARY_LOW, 8'h83);
      pa = {{10{s[0]}}, 8'hFE};
      pb = {{10{s[1]}}, 8'h83};
      pp = pa * pb;
      i_core.op(1'b0, `MAC_OPC_BYTE_PRODUCT, n);
      chk("byte_cycles", 40'h2, 40'(n));
      i_core.rd(`MAC_OFS_PRIMARY_LOW, d, h);
      chk("product_low", 40'(pp[7:0]), 40'(d));
      i_core.rd(`MAC_OFS_SECONDARY_LOW, d, h);
      chk("product_high", 40'(pp[15:8]), 40'(d));
    end
  endtask
  initial begin
    rst_n = 1'b0;
    m = '0;
    wrap = 1'b0;
    sgn = 2'h3; // Both sign selects set while multiply-adds run
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_window_clear();
    do_mac(16'hFFFD, 16'h1234);
    do_mac(16'h8000, 16'h8000);
    t_shift();
    t_wrap();
    t_byte();
    print_verdict();
  end
endmodule // mac_unit_tb

bind mac_unit mac_unit_chk i_chk (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
  .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
  .i_op_valid(i_op_valid), .i_op_prefixed(i_op_prefixed), .i_op_code(i_op_code), .o_op_busy(o_op_busy),
  .o_op_done(o_op_done), .i_wrap_clr(i_wrap_clr), .o_carry_valid(o_carry_valid),
  .o_twos_wrap_flag(o_twos_wrap_flag), .o_signal_proc_config(o_signal_proc_config));
`default_nettype wire
